// ==== dl_tx_consts.svh ====
`ifndef DL_TX_CONSTS_SVH
`define DL_TX_CONSTS_SVH
// register indices, byte address is four times the index
`define IDX_CFG 8'h33
`define IDX_STAT 8'h34
`define IDX_OVH 8'h35
`define IDX_FMASK 8'h36
`define IDX_EVT 8'h3A
`define IDX_EMASK 8'h3B
`define IDX_BUF 8'h40
// field positions
`define CFG_EN 0
`define CFG_LEN 1
`define CFG_RPT 3
`define ST_GO 3
`define OVH_OVR 4
`define OVH_PERR 3
`define CFG_RST 8'h08
`define REG_RST 8'h00
// frame layout
`define FLAG_BYTE 8'h7E
`define HDR_BYTES 7'h04
`define MSG_SHORT 7'h4C
`define MSG_LONG 7'h52
`define BUF_BYTES 86
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h8408
`define STUFF_RUN 3'h5
// timing
`define CLK_MHZ 50
`define ONE_SEC_US 1000000
`endif

// ==== dl_tx_pkg.sv ====
package dl_tx_pkg;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_OPEN = 3'b001,
      S_BODY = 3'b010,
      S_FCS = 3'b011,
      S_CLOSE = 3'b100,
      S_WAIT = 3'b101
   } tx_state_t;
   typedef struct packed {
      logic [2:0] febe;
      logic p;
      logic [3:0] f;
      logic [2:0] m;
   } ovh_bits_t;
endpackage : dl_tx_pkg

// ==== dl_tx.sv ====
// What this block does
// R1 - with repeat off the frame is sent once and the sender then waits for a new start.
// R2 - with repeat on the frame is resent until the sender is disabled; the sender resends one second after each frame ends.
// R3 - length select picks a 76 byte message when clear and 82 bytes when set.
// R4 - the sender must be enabled before a start, and the enable resets to zero.
// R5 - a start fetches header and message, 80 or 86 bytes, from the message buffer.
// R6 - a 16 bit check sequence is computed and sent in two octets after the payload.
// R7 - content between the 0x7E flags is zero stuffed.
// R8 - writing one to the start bit begins sending the frame in outgoing frames.
// R9 - busy reads one while a frame is sent and zero once it ends.
// R10 - the done flag sets when a frame ends and clears when its register is read.
// R11 - the done interrupt is raised only while its enable bit is one.
// R12 - with the override set, the user bits replace the generated block error bits.
// R13 - with parity error insertion set, every P bit is sent inverted.
// R14 - each M bit is xored with its mask bit.
// R15 - the first four F bits are xored with a four bit mask.
// R16 - software keeps the M and F masks at zero for normal operation.
// R17 - a start while disabled or busy is ignored and leaves the frame alone.
`timescale 1ns/10ps
`include "dl_tx_consts.svh"
module dl_tx import dl_tx_pkg::*; #(
   parameter int ONE_SEC_CYC = `ONE_SEC_US * `CLK_MHZ,
   parameter int BUF_DEPTH = `BUF_BYTES
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // data link bit stream to the framer
   input wire logic dl_bit_req,
   output logic dl_bit,
   output logic dl_bit_valid,
   // overhead bits through the error inserter
   input wire ovh_bits_t ovh_in,
   output ovh_bits_t ovh_out,
   // interrupt
   output logic irq
);
   if (BUF_DEPTH != `BUF_BYTES || ONE_SEC_CYC < 1) begin : g_bad_param
      $error("dl_tx: unsupported parameter values");
   end

   // ****************
   // bus slave
   // ****************
   logic dp_wr, dp_rd, rd_done;
   logic [7:0] dp_idx;
   logic [7:0] cfg, ovh_reg;
   logic [3:0] fmask;
   logic irq_en, done_flag;
   logic [1:0] evt, emask;
   logic [7:0] msg_buf [BUF_DEPTH];
   tx_state_t state;
   logic [2:0] bit_cnt, ones;
   logic [6:0] byte_idx;
   logic [15:0] crc;
   logic [31:0] sec_cnt;

   wire addr_ok = hsel & htrans[1] & hready;
   wire rd_fire = dp_rd & ~rd_done;
   wire [7:0] wd = hwdata[7:0];
   wire sel_cfg = dp_idx == `IDX_CFG;
   wire sel_stat = dp_idx == `IDX_STAT;
   wire sel_ovh = dp_idx == `IDX_OVH;
   wire sel_fm = dp_idx == `IDX_FMASK;
   wire sel_evt = dp_idx == `IDX_EVT;
   wire sel_em = dp_idx == `IDX_EMASK;
   wire sel_buf = dp_idx >= `IDX_BUF && dp_idx < 8'(`IDX_BUF + BUF_DEPTH);
   wire [6:0] buf_off = 7'(dp_idx - `IDX_BUF);
   wire wr_cfg = dp_wr & sel_cfg;
   wire wr_stat = dp_wr & sel_stat;
   wire rd_stat = rd_fire & sel_stat;
   wire en = cfg[`CFG_EN];
   wire busy = state inside {S_OPEN, S_BODY, S_FCS, S_CLOSE};
   wire [7:0] stat_byte = {5'h00, busy, irq_en, done_flag};
   wire [7:0] rd_byte = sel_cfg ? cfg : sel_stat ? stat_byte : sel_ovh ? ovh_reg :
      sel_fm ? {4'h0, fmask} : sel_evt ? {6'h00, evt} : sel_em ? {6'h00, emask} :
      sel_buf ? msg_buf[buf_off] : 8'h00;

   assign hreadyout = ~rd_fire;
   assign hresp = 1'b0;

   // reads take one wait state so hrdata comes from a flop
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dp_wr <= 1'b0;
         dp_rd <= 1'b0;
         dp_idx <= 8'h00;
         rd_done <= 1'b0;
         hrdata <= 32'h0;
      end else begin
         if (hready) begin
            dp_wr <= addr_ok & hwrite;
            dp_rd <= addr_ok & ~hwrite;
            dp_idx <= addr_ok ? haddr[9:2] : dp_idx;
         end
         rd_done <= rd_fire;
         if (rd_fire) begin
            hrdata <= {24'h0, rd_byte};
         end
      end
   end

   // ****************
   // registers
   // ****************
   logic done_evt, abort_evt;
   // start needs enable and not busy (idle or wait), so a late start cannot corrupt the frame in flight
   wire go_ok = wr_stat & wd[`ST_GO] & en & ~busy; // R8 R17

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cfg <= `CFG_RST; // R4
         ovh_reg <= `REG_RST;
         fmask <= 4'h0;
         irq_en <= 1'b0;
         done_flag <= 1'b0;
         evt <= 2'h0;
         emask <= 2'h0;
      end else begin
         if (wr_cfg) begin
            cfg <= wd & {4'h0, 1'b1, 1'b0, 2'h3};
         end
         if (wr_stat) begin
            irq_en <= wd[1];
         end
         if (dp_wr & sel_ovh) begin
            ovh_reg <= wd;
         end
         if (dp_wr & sel_fm) begin
            fmask <= wd[3:0];
         end
         if (dp_wr & sel_em) begin
            emask <= wd[1:0];
         end
         done_flag <= done_evt | (done_flag & ~rd_stat); // R10
         evt <= (evt & ~((dp_wr & sel_evt) ? wd[1:0] : 2'h0)) | {abort_evt, done_evt & irq_en}; // R11
      end
   end

   // message buffer is plain storage, no reset
   always_ff @(posedge clock) begin
      if (dp_wr & sel_buf) begin
         msg_buf[buf_off] <= wd;
      end
   end

   assign irq = |(evt & emask);

   // ****************
   // frame sender
   // ****************
   wire rpt = cfg[`CFG_RPT];
   wire [6:0] fetch_n = `HDR_BYTES + (cfg[`CFG_LEN] ? `MSG_LONG : `MSG_SHORT); // R3 R5
   wire data_st = state == S_BODY || state == S_FCS;
   // stuffing also guards the closing flag, else six ones could fake it
   wire stuff = ones == `STUFF_RUN && (data_st || state == S_CLOSE); // R7
   wire step = dl_bit_req & busy;
   wire [7:0] cur_byte = msg_buf[byte_idx];
   wire [7:0] flag_byte = `FLAG_BYTE;
   wire cur_bit = state == S_BODY ? cur_byte[bit_cnt] : state == S_FCS ? ~crc[0] : flag_byte[bit_cnt];
   wire [15:0] crc_next = (crc >> 1) ^ ((crc[0] ^ cur_bit) ? `CRC_POLY : 16'h0000); // R6
   wire byte_end = step & ~stuff & bit_cnt == 3'h7;
   // interval counted from frame end, so a long frame never overlaps the next
   wire sec_end = sec_cnt == 32'(ONE_SEC_CYC - 1);

   assign done_evt = byte_end & state == S_CLOSE;
   // a cut frame has no closing flag, so the far end drops it
   assign abort_evt = busy & ~en;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state <= S_IDLE;
         bit_cnt <= 3'h0;
         byte_idx <= 7'h00;
         ones <= 3'h0;
         crc <= `CRC_INIT;
         sec_cnt <= 32'h0;
         dl_bit <= 1'b0;
         dl_bit_valid <= 1'b0;
      end else begin
         dl_bit_valid <= step;
         sec_cnt <= state == S_WAIT ? sec_cnt + 32'h1 : 32'h0;
         if (step) begin
            dl_bit <= stuff ? 1'b0 : cur_bit; // R7
            ones <= (~stuff & data_st & cur_bit) ? ones + 3'h1 : 3'h0;
            if (~stuff) begin
               bit_cnt <= bit_cnt + 3'h1;
               crc <= state == S_BODY ? crc_next : state == S_FCS ? crc >> 1 : crc; // R6
            end
         end
         if (~en) begin
            state <= S_IDLE; // R2 R4
         end else if (go_ok || (state == S_WAIT && sec_end)) begin
            state <= S_OPEN; // R8 R2
            bit_cnt <= 3'h0;
            ones <= 3'h0;
            crc <= `CRC_INIT;
         end else if (byte_end) begin
            unique case (state)
               S_OPEN: begin
                  state <= S_BODY;
                  byte_idx <= 7'h00;
               end
               S_BODY: begin
                  byte_idx <= byte_idx + 7'h01; // R5
                  if (byte_idx == fetch_n - 7'h01) begin
                     state <= S_FCS;
                     byte_idx <= 7'h00;
                  end
               end
               S_FCS: begin
                  byte_idx <= byte_idx + 7'h01;
                  if (byte_idx == 7'h01) begin
                     state <= S_CLOSE;
                  end
               end
               S_CLOSE: begin
                  state <= rpt ? S_WAIT : S_IDLE; // R1 R2 R9
               end
               default: begin
                  state <= state;
               end
            endcase
         end
      end
   end

   // ****************
   // overhead error insertion
   // ****************
   // registered so the inserted bits line up one clock after ovh_in
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ovh_out <= '0;
      end else begin
         ovh_out.febe <= ovh_reg[`OVH_OVR] ? ovh_reg[7:5] : ovh_in.febe; // R12
         ovh_out.p <= ovh_in.p ^ ovh_reg[`OVH_PERR]; // R13
         ovh_out.m <= ovh_in.m ^ ovh_reg[2:0]; // R14 R16
         ovh_out.f <= ovh_in.f ^ fmask; // R15 R16
      end
   end

   // ****************
   // assertions
   // ****************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   AST_ONE_SHOT: assert property (done_evt & en & ~rpt |=> state == S_IDLE ##1 (state == S_IDLE || $past(go_ok))) // R1
      else $error("one shot did not stop");
   AST_REPEAT: assert property (done_evt & en & rpt |=> state == S_WAIT && sec_cnt == 32'h0) // R2
      else $error("repeat did not wait");
   AST_LEN: assert property (byte_end & state == S_BODY & byte_idx == fetch_n - 7'h01 & en |=> state == S_FCS) // R3
      else $error("body length wrong");
   AST_DISABLED: assert property (!en |=> state == S_IDLE && !busy) // R4
      else $error("disabled sender active");
   AST_FCS_BIT: assert property (step & ~stuff & state == S_FCS |=> dl_bit == !$past(crc[0])) // R6
      else $error("fcs bit wrong");
   AST_STUFF: assert property (step & data_st & ones == `STUFF_RUN |=> !dl_bit && ones == 3'h0) // R7
      else $error("missing stuffed zero");
   AST_GO: assert property (go_ok |=> state == S_OPEN && busy && bit_cnt == 3'h0) // R8
      else $error("start not taken");
   AST_BUSY: assert property (done_evt |=> !busy && done_flag) // R9
      else $error("busy not cleared at end");
   AST_FLAG_RD: assert property (rd_stat & ~done_evt |=> !done_flag) // R10
      else $error("flag not cleared by read");
   AST_IRQ_EN: assert property (done_evt & !irq_en & !evt[0] |=> !evt[0]) // R11
      else $error("masked done raised event");
   AST_FEBE: assert property (ovh_reg[`OVH_OVR] |=> ovh_out.febe == $past(ovh_reg[7:5])) // R12
      else $error("febe override wrong");
   AST_PERR: assert property (ovh_reg[`OVH_PERR] |=> ovh_out.p != $past(ovh_in.p)) // R13
      else $error("parity not inverted");
   AST_MBIT: assert property (1'b1 |=> ovh_out.m == ($past(ovh_in.m) ^ $past(ovh_reg[2:0]))) // R14
      else $error("m bit mask wrong");
   AST_FBIT: assert property (1'b1 |=> ovh_out.f == ($past(ovh_in.f) ^ $past(fmask))) // R15
      else $error("f bit mask wrong");
   AST_IGNORE: assert property (wr_stat & wd[`ST_GO] & busy & en |=> state != S_OPEN || $past(state) == S_OPEN) // R17
      else $error("start disturbed frame");

   // ****************
   // assertions, frame sender
   // ****************
   // checks that expect a state other than S_IDLE carry en: a cleared enable cuts the frame short
   AST_GO_IDLE: assert property (state == S_IDLE && !go_ok |=> state == S_IDLE) // R1
      else $error("idle sender left idle");
   AST_WAIT_LEN: assert property (state == S_WAIT && sec_end && en |=> state == S_OPEN) // R2
      else $error("resend not started");
   AST_WAIT_QUIET: assert property (state == S_WAIT && !sec_end && en && !go_ok |=> state == S_WAIT) // R2
      else $error("wait ended early");
   AST_SEC_CNT: assert property (state == S_WAIT |=> sec_cnt == $past(sec_cnt) + 32'h1) // R2
      else $error("interval count stalled");
   AST_BODY_BIT: assert property (step & ~stuff & state == S_BODY |=> dl_bit == $past(cur_bit)) // R5
      else $error("body bit wrong");
   AST_BIT_STEP: assert property (step & ~stuff |=> bit_cnt == $past(bit_cnt) + 3'h1) // R5
      else $error("bit count did not step");
   AST_FCS_LEN: assert property (byte_end & state == S_FCS & byte_idx == 7'h01 & en |=> state == S_CLOSE) // R6
      else $error("check sequence length wrong");
   AST_CRC_HOLD: assert property (step & stuff |=> crc == $past(crc) && bit_cnt == $past(bit_cnt)) // R7
      else $error("stuffed bit touched check sequence");
   AST_OPEN_ONES: assert property (step & state == S_OPEN |=> ones == 3'h0) // R7
      else $error("flag counted as data");
   AST_OPEN_NEXT: assert property (byte_end & state == S_OPEN & en |=> state == S_BODY && byte_idx == 7'h00) // R7
      else $error("body did not follow flag");
   AST_VALID_STEP: assert property (step |=> dl_bit_valid) // R8
      else $error("accepted slot gave no bit");
   AST_VALID_IDLE: assert property (!busy |=> !dl_bit_valid) // R9
      else $error("bit sent while not busy");
   AST_IGNORE_OFF: assert property (wr_stat & wd[`ST_GO] & ~en |=> !busy) // R17
      else $error("start taken while disabled");

   // ****************
   // assertions, registers and overhead
   // ****************
   // set beats clear on every sticky bit, so no event is lost to a read
   AST_ABORT: assert property (busy & ~en |=> evt[1]) // R4
      else $error("abort event missing");
   AST_EN_RD: assert property (rd_fire & sel_cfg |=> hrdata[0] == $past(en)) // R4
      else $error("enable read wrong");
   AST_BUSY_RD: assert property (rd_fire & sel_stat |=> hrdata[2] == $past(busy)) // R9
      else $error("busy read wrong");
   AST_DONE_RD: assert property (rd_stat |=> hrdata[0] == $past(done_flag)) // R10
      else $error("done flag read wrong");
   AST_FLAG_HOLD: assert property (done_flag & ~rd_stat |=> done_flag) // R10
      else $error("done flag lost");
   AST_IRQ_OUT: assert property (done_evt & irq_en & emask[0] & ~(dp_wr & sel_em) |=> irq) // R11
      else $error("enabled done raised no interrupt");
   AST_EVT_CLR: assert property (dp_wr & sel_evt & wd[0] & ~done_evt |=> !evt[0]) // R11
      else $error("event not cleared by write");
   AST_FEBE_PASS: assert property (!ovh_reg[`OVH_OVR] |=> ovh_out.febe == $past(ovh_in.febe)) // R12
      else $error("generated febe not passed");
   AST_PAR_PASS: assert property (!ovh_reg[`OVH_PERR] |=> ovh_out.p == $past(ovh_in.p)) // R13
      else $error("correct parity not passed");
endmodule : dl_tx

// ==== dl_tx_framer_model.sv ====
`timescale 1ns/10ps
// ****************************************
// framer side: slot strobe and frame capture
// ****************************************
module dl_tx_framer_model (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // data link slot
   input wire logic dl_bit,
   input wire logic dl_bit_valid,
   output logic dl_bit_req
);
   logic [7:0] rx_bytes [0:95];
   int rx_len = 0;
   int frames = 0;
   int ones = 0;
   int slot = 0;
   logic [7:0] win = 8'h00;
   bit q[$];
   // one slot in four skipped, as overhead would
   always @(posedge clock) begin
      slot <= slot + 1;
      dl_bit_req <= reset_n && (slot % 4 != 3);
   end
   always @(posedge clock) begin
      if (dl_bit_valid === 1'b1) begin
         win = {dl_bit, win[7:1]};
         if (ones == 5 && dl_bit == 1'b0) begin
            ones = 0;
         end else begin
            q.push_back(dl_bit);
            ones = dl_bit ? ones + 1 : 0;
         end
         if (win == 8'h7E) begin
            if (q.size() >= 16) begin
               repeat (8) void'(q.pop_back());
               rx_len = q.size() / 8;
               for (int i = 0; i < rx_len * 8; i++) rx_bytes[i / 8][i % 8] = q[i];
               frames++;
            end
            q.delete();
            ones = 0;
         end
      end
   end
endmodule : dl_tx_framer_model

// ==== tb_ds3_datalink_tx_and_error_insert.sv ====
`timescale 1ns/10ps
`include "dl_tx_consts.svh"
// ****************************************
// bench: register bus, frame capture, overhead
// ****************************************
module tb_ds3_datalink_tx_and_error_insert import dl_tx_pkg::*;;
   logic clock, reset_n, hsel, hwrite, hreadyout, hresp, dl_bit_req, dl_bit, dl_bit_valid, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   ovh_bits_t ovh_in, ovh_out;
   logic [7:0] rdata_s, v;
   int errors = 0;
   int num_checks = 0;
   // short second keeps the repeat case quick
   dl_tx #(.ONE_SEC_CYC(200)) uut (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dl_bit_req(dl_bit_req),
      .dl_bit(dl_bit), .dl_bit_valid(dl_bit_valid), .ovh_in(ovh_in), .ovh_out(ovh_out), .irq(irq));
   dl_tx_framer_model model (.clock(clock), .reset_n(reset_n), .dl_bit(dl_bit),
      .dl_bit_valid(dl_bit_valid), .dl_bit_req(dl_bit_req));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // ready sampled mid-cycle, away from the edge that moves it
   task automatic wait_ready;
      @(negedge clock);
      while (hreadyout !== 1'b1) @(negedge clock);
      rdata_s = hrdata[7:0];
      @(posedge clock);
   endtask : wait_ready
   task automatic bus(input logic wr_n, input logic [7:0] idx, input logic [7:0] wd);
      htrans <= 2'b10;
      hwrite <= ~wr_n;
      haddr <= {22'h0, idx, 2'b00};
      wait_ready();
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      wait_ready();
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b0, idx, d);
   endtask : wr
   task automatic rd(input logic [7:0] idx, output logic [7:0] d);
      bus(1'b1, idx, 8'h00);
      d = rdata_s;
   endtask : rd
   function automatic logic [7:0] bval(input int i);
      return (i % 5 == 0) ? 8'hFF : 8'(i);
   endfunction : bval
   function automatic logic [15:0] fcs(input int n);
      logic [15:0] c;
      c = `CRC_INIT;
      for (int i = 0; i < n; i++) begin
         c = c ^ {8'h00, bval(i)};
         repeat (8) c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
      end
      return ~c;
   endfunction : fcs
   task automatic wait_frame(input int n);
      for (int i = 0; i < 4000 && model.frames < n; i++) @(posedge clock);
      repeat (4) @(posedge clock);
      chk("frames", n, model.frames);
   endtask : wait_frame
   task automatic t_reset;
      rd(`IDX_CFG, v);
      chk("cfg reset", `CFG_RST, v);
      rd(`IDX_STAT, v);
      chk("stat reset", 8'h00, v);
      rd(`IDX_OVH, v);
      chk("ovh reset", 8'h00, v);
      rd(`IDX_FMASK, v);
      chk("fmask reset", 8'h00, v);
      rd(8'h20, v);
      chk("unmapped", 8'h00, v);
      chk("hresp", 1'b0, hresp);
      for (int i = 0; i < `BUF_BYTES; i++) wr(8'(`IDX_BUF + i), bval(i));
      wr(`IDX_STAT, 8'h08);
      repeat (20) @(posedge clock);
      rd(`IDX_STAT, v);
      chk("start disabled", 8'h00, v);
      $display("done reset and disabled start");
   endtask : t_reset
   task automatic t_oneshot;
      wr(`IDX_CFG, 8'h01);
      wr(`IDX_EMASK, 8'h01);
      wr(`IDX_STAT, 8'h0A);
      rd(`IDX_STAT, v);
      chk("busy", 8'h06, v & 8'h06);
      wr(`IDX_STAT, 8'h0A);
      wait_frame(1);
      chk("length", `HDR_BYTES + `MSG_SHORT + 2, model.rx_len);
      for (int i = 0; i < 80; i++) chk("byte", bval(i), model.rx_bytes[i]);
      chk("fcs", fcs(80), {model.rx_bytes[81], model.rx_bytes[80]});
      rd(`IDX_STAT, v);
      chk("done", 8'h03, v);
      rd(`IDX_STAT, v);
      chk("cleared", 8'h02, v);
      chk("irq", 1'b1, irq);
      rd(`IDX_EVT, v);
      chk("event", 8'h01, v);
      wr(`IDX_EVT, 8'h01);
      @(negedge clock);
      chk("irq clear", 1'b0, irq);
      repeat (300) @(posedge clock);
      chk("no resend", 1, model.frames);
      $display("done one shot");
   endtask : t_oneshot
   task automatic t_repeat;
      wr(`IDX_CFG, 8'h0B);
      wr(`IDX_STAT, 8'h08);
      wait_frame(2);
      chk("long length", `HDR_BYTES + `MSG_LONG + 2, model.rx_len);
      chk("long fcs", fcs(86), {model.rx_bytes[87], model.rx_bytes[86]});
      rd(`IDX_EVT, v);
      chk("masked event", 8'h00, v);
      chk("no irq", 1'b0, irq);
      repeat (150) @(posedge clock);
      rd(`IDX_STAT, v);
      chk("pause", 8'h01, v);
      repeat (100) @(posedge clock);
      rd(`IDX_STAT, v);
      chk("resent", 8'h04, v & 8'h04);
      wr(`IDX_CFG, 8'h08);
      rd(`IDX_STAT, v);
      chk("stopped", 8'h00, v & 8'h04);
      rd(`IDX_EVT, v);
      chk("abort event", 8'h02, v);
      repeat (1500) @(posedge clock);
      chk("no more", 2, model.frames);
      $display("done repeat");
   endtask : t_repeat
   task automatic t_ovh;
      ovh_in <= 11'h29B;
      wr(`IDX_OVH, 8'hB5);
      wr(`IDX_FMASK, 8'hFA);
      rd(`IDX_FMASK, v);
      chk("fmask bits", 8'h0A, v);
      rd(`IDX_OVH, v);
      chk("ovh reg", 8'hB5, v);
      @(negedge clock);
      chk("ovh masked", 11'h5CE, ovh_out);
      wr(`IDX_OVH, 8'h48);
      wr(`IDX_FMASK, 8'h00);
      repeat (2) @(negedge clock);
      chk("ovh parity", 11'h21B, ovh_out);
      wr(`IDX_OVH, 8'h00);
      repeat (2) @(negedge clock);
      chk("ovh clean", 11'h29B, ovh_out);
      $display("done overhead");
   endtask : t_ovh
   initial begin
      reset_n = 1'b0;
      hsel = 1'b1;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      haddr = 32'h0;
      hwdata = 32'h0;
      ovh_in = 11'h0;
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      t_reset();
      t_oneshot();
      t_repeat();
      t_ovh();
      report_and_stop();
   end
   initial begin
      repeat (30000) @(posedge clock);
      errors++;
      report_and_stop();
   end
endmodule : tb_ds3_datalink_tx_and_error_insert
